// [core/mcu_bus_interface.sv]
/*
 * Parallel bus port of the device toward an 8-bit microcontroller:
 * synchronises the pins, latches the address on the address strobe,
 * decodes strobes per configuration, feeds the decoder array and
 * drives read data, when selected, onto the low port (multiplexed), the high port (page) or both (burst); never in non-multiplexed mode.
 * Assumes strap-like configuration inputs are static during cycles and
 * internal read data arrives on the same clock.
 */
// Summary of operation
// - address captured by address strobe and held for the bus cycle, except in non-multiplexed mode, where the latch stays open
// - data drivers on only during read with a block selected
// - address bits from both ports feed the decoder array
// - first control input: write strobe or read-not-write level
// - second control: read strobe, phase clock, data strobe or fetch read
// - third control: code-only fetch strobe or generic input
// - all three control levels reach the decode logic
// - reset returns ports, outputs and state to reset values
// - decoder makes selects from latched address; selects gate drive
`timescale 1ns/1ps
`default_nettype none

module mcu_bus_interface #(
    parameter int N_SEL = mcu_bus_pkg::N_SEL_DEF
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire mcu_bus_pkg::cfg_t I_CFG,
    input wire logic [mcu_bus_pkg::BYTE_W-1:0] I_LOW_ADDR_DATA_PORT,
    output logic [mcu_bus_pkg::BYTE_W-1:0] O_LOW_ADDR_DATA_PORT,
    output logic O_LOW_ADDR_DATA_PORT_OE_N,
    input wire logic [mcu_bus_pkg::BYTE_W-1:0] I_HIGH_ADDR_DATA_PORT,
    output logic [mcu_bus_pkg::BYTE_W-1:0] O_HIGH_ADDR_DATA_PORT,
    output logic O_HIGH_ADDR_DATA_PORT_OE_N,
    input wire logic I_ADDRESS_STROBE_IN,
    input wire logic I_WRITE_CTRL_INPUT,
    input wire logic I_READ_CTRL_INPUT,
    input wire logic I_PROGRAM_SELECT_INPUT,
    input wire logic [N_SEL-1:0][mcu_bus_pkg::ADDR_W-1:0] I_SEL_MATCH,
    input wire logic [N_SEL-1:0][mcu_bus_pkg::ADDR_W-1:0] I_SEL_MASK,
    input wire logic [N_SEL-1:0] I_SEL_CODE_ONLY,
    input wire logic [N_SEL-1:0][mcu_bus_pkg::CTRL_W-1:0] I_SEL_CTRL_CARE,
    input wire logic [N_SEL-1:0][mcu_bus_pkg::CTRL_W-1:0] I_SEL_CTRL_VAL,
    input wire logic [mcu_bus_pkg::WORD_W-1:0] I_RD_DATA,
    output mcu_bus_pkg::cycle_t O_CYCLE,
    output logic [N_SEL-1:0] O_SEL,
    output logic [mcu_bus_pkg::CTRL_W-1:0] O_CTRL_LEVELS,
    output logic [mcu_bus_pkg::WORD_W-1:0] O_WR_DATA
);

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [mcu_bus_pkg::SYNC_W-1:0] pins;
    logic [mcu_bus_pkg::SYNC_W-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
    logic [mcu_bus_pkg::SYNC_W-1:0] agree, nxt_pin;

    assign pins = {I_HIGH_ADDR_DATA_PORT, I_LOW_ADDR_DATA_PORT,
                   I_PROGRAM_SELECT_INPUT, I_READ_CTRL_INPUT,
                   I_WRITE_CTRL_INPUT, I_ADDRESS_STROBE_IN};
    // a bit changes only once stages two and three agree
    assign agree = ~(s2_ff ^ s3_ff);
    assign nxt_pin = (agree & s3_ff) | (~agree & pin_ff);

    // three-stage chain plus accepted value
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s1_ff <= mcu_bus_pkg::SYNC_RST;
            s2_ff <= mcu_bus_pkg::SYNC_RST;
            s3_ff <= mcu_bus_pkg::SYNC_RST;
            pin_ff <= mcu_bus_pkg::SYNC_RST;
        end else begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    wire ale_lvl = pin_ff[mcu_bus_pkg::SYNC_ALE];
    wire [mcu_bus_pkg::CTRL_W-1:0] ctrl =
        pin_ff[mcu_bus_pkg::SYNC_CTRL_LSB +: mcu_bus_pkg::CTRL_W];
    wire [mcu_bus_pkg::BYTE_W-1:0] lo_in =
        pin_ff[mcu_bus_pkg::SYNC_LO_LSB +: mcu_bus_pkg::BYTE_W];
    wire [mcu_bus_pkg::BYTE_W-1:0] hi_in =
        pin_ff[mcu_bus_pkg::SYNC_HI_LSB +: mcu_bus_pkg::BYTE_W];
    wire c0 = ctrl[0];
    wire c1 = ctrl[1];
    wire c2 = ctrl[2];

    // ------------------------------------------------------------
    // address assembly and latch
    // ------------------------------------------------------------
    // burst hosts put A4-A19 on the ports; others A0-A15
    function automatic logic [mcu_bus_pkg::ADDR_W-1:0] build_addr(
        input mcu_bus_pkg::bus_mode_t mode,
        input logic [mcu_bus_pkg::BYTE_W-1:0] lo,
        input logic [mcu_bus_pkg::BYTE_W-1:0] hi
    );
        if (mode == mcu_bus_pkg::BUS_BURST) begin
            build_addr = {hi, lo, mcu_bus_pkg::ADDR_PAD};
        end else begin
            build_addr = {mcu_bus_pkg::ADDR_PAD, hi, lo};
        end
    endfunction

    wire is_burst = I_CFG.bus_mode == mcu_bus_pkg::BUS_BURST;
    wire is_page = I_CFG.bus_mode == mcu_bus_pkg::BUS_PAGE;
    wire is_nonmux = I_CFG.bus_mode == mcu_bus_pkg::BUS_NONMUX;
    wire ale_act = I_CFG.strobe_active_low ? ~ale_lvl : ale_lvl;
    // non-multiplexed address is live, so the latch stays open
    wire latch_en = ale_act | is_nonmux;
    wire [mcu_bus_pkg::ADDR_W-1:0] addr_in = build_addr(I_CFG.bus_mode,
                                                        lo_in, hi_in);

    // ------------------------------------------------------------
    // strobe decoding
    // ------------------------------------------------------------
    wire c0_is_rnw = I_CFG.ctrl0_mode == mcu_bus_pkg::C0_READ_NOT_WRITE;
    wire c1_is_strobe = I_CFG.ctrl1_mode == mcu_bus_pkg::C1_READ_STROBE
                     || I_CFG.ctrl1_mode == mcu_bus_pkg::C1_FETCH_READ;
    // phase clock high or data strobe low marks the data phase
    wire qual = (I_CFG.ctrl1_mode == mcu_bus_pkg::C1_PHASE_CLOCK) ? c1
              : (I_CFG.ctrl1_mode == mcu_bus_pkg::C1_DATA_STROBE) ? ~c1
              : 1'b1;
    wire rd_main = c1_is_strobe ? ~c1 : (qual & c0);
    wire wr_main = c0_is_rnw ? (~c0 & qual) : ~c0;
    wire code = I_CFG.fetch_on_ctrl2 & ~c2;
    wire rd_any = rd_main | code;

    // ------------------------------------------------------------
    // decoder array
    // ------------------------------------------------------------
    logic [mcu_bus_pkg::ADDR_W-1:0] addr_ff;
    logic [N_SEL-1:0] sel;

    address_decoder_array #(.N_SEL(N_SEL)) u_dec (
        .i_addr(addr_ff),
        .i_ctrl(ctrl),
        .i_code(code),
        .i_match(I_SEL_MATCH),
        .i_mask(I_SEL_MASK),
        .i_code_only(I_SEL_CODE_ONLY),
        .i_ctrl_care(I_SEL_CTRL_CARE),
        .i_ctrl_val(I_SEL_CTRL_VAL),
        .o_sel(sel)
    );

    // ------------------------------------------------------------
    // cycle state and drive enables
    // ------------------------------------------------------------
    logic rd_ff, wr_ff, code_ff, lo_drive_ff, hi_drive_ff;
    logic [N_SEL-1:0] sel_ff;
    logic [mcu_bus_pkg::WORD_W-1:0] rdata_ff, wdata_ff;
    wire any_sel = |sel;
    // non-multiplexed hosts keep their address on the low port all cycle
    wire nxt_lo_drive = rd_any & any_sel & ~is_page & ~is_nonmux;
    wire nxt_hi_drive = rd_any & any_sel & (is_page | is_burst);
    wire [mcu_bus_pkg::ADDR_W-1:0] nxt_addr = latch_en ? addr_in : addr_ff;
    wire [mcu_bus_pkg::WORD_W-1:0] nxt_wdata = wr_main ? {hi_in, lo_in}
                                                       : wdata_ff;

    // all state returns to constants under reset
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            addr_ff <= mcu_bus_pkg::ADDR_RST;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            code_ff <= 1'b0;
            sel_ff <= '0;
            lo_drive_ff <= 1'b0;
            hi_drive_ff <= 1'b0;
            rdata_ff <= mcu_bus_pkg::WORD_RST;
            wdata_ff <= mcu_bus_pkg::WORD_RST;
        end else begin
            addr_ff <= nxt_addr;
            rd_ff <= rd_any;
            wr_ff <= wr_main;
            code_ff <= code;
            sel_ff <= sel;
            lo_drive_ff <= nxt_lo_drive;
            hi_drive_ff <= nxt_hi_drive;
            rdata_ff <= I_RD_DATA;
            wdata_ff <= nxt_wdata;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // page hosts read on the high port, burst hosts on both
    assign O_LOW_ADDR_DATA_PORT = rdata_ff[mcu_bus_pkg::BYTE_W-1:0];
    assign O_HIGH_ADDR_DATA_PORT = is_burst
        ? rdata_ff[mcu_bus_pkg::WORD_W-1:mcu_bus_pkg::BYTE_W]
        : rdata_ff[mcu_bus_pkg::BYTE_W-1:0];
    assign O_LOW_ADDR_DATA_PORT_OE_N = ~lo_drive_ff;
    assign O_HIGH_ADDR_DATA_PORT_OE_N = ~hi_drive_ff;
    assign O_CYCLE = '{addr: addr_ff, rd: rd_ff, wr: wr_ff, code: code_ff};
    assign O_SEL = sel_ff;
    assign O_CTRL_LEVELS = ctrl;
    assign O_WR_DATA = wdata_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_drive_needs_read_sel;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        !O_LOW_ADDR_DATA_PORT_OE_N |-> $past(rd_any) && $past(|sel);
    endproperty
    a_drive_needs_read_sel: assert property (p_drive_needs_read_sel)
        else $error("low port driven without read and select");

    property p_no_sel_no_drive;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        !any_sel |=> O_LOW_ADDR_DATA_PORT_OE_N && O_HIGH_ADDR_DATA_PORT_OE_N;
    endproperty
    a_no_sel_no_drive: assert property (p_no_sel_no_drive)
        else $error("port driven with no block selected");

    property p_addr_held;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        !latch_en |=> $stable(addr_ff);
    endproperty
    a_addr_held: assert property (p_addr_held)
        else $error("address moved outside the strobe");

    property p_addr_capture;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        latch_en && !is_burst |=>
            addr_ff[mcu_bus_pkg::BYTE_W-1:0] == $past(lo_in)
            && O_CYCLE.addr[mcu_bus_pkg::WORD_W-1:mcu_bus_pkg::BYTE_W]
               == $past(hi_in);
    endproperty
    a_addr_capture: assert property (p_addr_capture)
        else $error("latched address differs from ports");

    property p_burst_map;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        latch_en && is_burst |=> addr_ff[11:4] == $past(lo_in)
                                 && addr_ff[19:12] == $past(hi_in);
    endproperty
    a_burst_map: assert property (p_burst_map)
        else $error("burst address bits misplaced");

    property p_rnw_qualified;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        c0_is_rnw && !c1_is_strobe && !qual |=> !O_CYCLE.wr;
    endproperty
    a_rnw_qualified: assert property (p_rnw_qualified)
        else $error("write seen outside the data strobe");

    property p_write_strobe;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        !c0_is_rnw |=> O_CYCLE.wr == !$past(c0);
    endproperty
    a_write_strobe: assert property (p_write_strobe)
        else $error("write strobe decode wrong");

    property p_sync_agree;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        $changed(pin_ff) |->
            ((pin_ff ^ $past(pin_ff))
             & ((pin_ff ^ $past(s2_ff)) | (pin_ff ^ $past(s3_ff)))) == '0;
    endproperty
    a_sync_agree: assert property (p_sync_agree)
        else $error("pin level accepted before stages agreed");

    property p_fetch_read;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CFG.fetch_on_ctrl2 && !c2 |=> O_CYCLE.rd && O_CYCLE.code;
    endproperty
    a_fetch_read: assert property (p_fetch_read)
        else $error("fetch strobe not seen as code read");

endmodule
`default_nettype wire

// [core/mcu_bus_pkg.sv]
/*
 * Shared constants and types for the microcontroller bus interface:
 * pin synchroniser layout, address assembly positions, strobe
 * configuration modes and the carrier structs of a bus cycle.
 * Assumes a single 100 MHz clock domain and no software registers.
 */
package mcu_bus_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int CTRL_W = 3;
    localparam int N_SEL_DEF = 4;

    // ------------------------------------------------------------
    // synchroniser vector layout (one bit per pin)
    // ------------------------------------------------------------
    localparam int SYNC_W = 20;
    localparam int SYNC_ALE = 0;
    localparam int SYNC_CTRL_LSB = 1;
    localparam int SYNC_LO_LSB = 4;
    localparam int SYNC_HI_LSB = 12;

    // ------------------------------------------------------------
    // reset values and fill patterns
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    // control strobes rest high, so reset shows them idle, not active
    localparam logic [SYNC_W-1:0] SYNC_RST = 20'h0_000E;
    localparam logic [3:0] ADDR_PAD = 4'h0;

    // ------------------------------------------------------------
    // modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BUS_MUX    = 4'b0001,
        BUS_NONMUX = 4'b0010,
        BUS_PAGE   = 4'b0100,
        BUS_BURST  = 4'b1000
    } bus_mode_t;

    typedef enum logic [1:0] {
        C0_WRITE_STROBE   = 2'b01,
        C0_READ_NOT_WRITE = 2'b10
    } ctrl0_mode_t;

    typedef enum logic [3:0] {
        C1_READ_STROBE = 4'b0001,
        C1_PHASE_CLOCK = 4'b0010,
        C1_DATA_STROBE = 4'b0100,
        C1_FETCH_READ  = 4'b1000
    } ctrl1_mode_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        bus_mode_t bus_mode;
        ctrl0_mode_t ctrl0_mode;
        ctrl1_mode_t ctrl1_mode;
        logic fetch_on_ctrl2;   // third control input is a fetch strobe
        logic strobe_active_low; // address strobe polarity
    } cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic code;
    } cycle_t;

endpackage

// [core/address_decoder_array.sv]
/*
 * Address decoder array: each select output is a product term of the
 * latched address under a mask, optionally qualified by the program
 * fetch strobe. Combinational; the caller registers the selects.
 * Assumes address and control levels are already in the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module address_decoder_array #(
    parameter int N_SEL = mcu_bus_pkg::N_SEL_DEF
) (
    input wire logic [mcu_bus_pkg::ADDR_W-1:0] i_addr,
    input wire logic [mcu_bus_pkg::CTRL_W-1:0] i_ctrl,
    input wire logic i_code,
    input wire logic [N_SEL-1:0][mcu_bus_pkg::ADDR_W-1:0] i_match,
    input wire logic [N_SEL-1:0][mcu_bus_pkg::ADDR_W-1:0] i_mask,
    input wire logic [N_SEL-1:0] i_code_only,
    input wire logic [N_SEL-1:0][mcu_bus_pkg::CTRL_W-1:0] i_ctrl_care,
    input wire logic [N_SEL-1:0][mcu_bus_pkg::CTRL_W-1:0] i_ctrl_val,
    output logic [N_SEL-1:0] o_sel
);

    // ------------------------------------------------------------
    // product terms
    // ------------------------------------------------------------
    // one term per select: address hit, control levels, fetch space
    genvar g;
    generate
        for (g = 0; g < N_SEL; g++) begin : g_term
            wire addr_hit = ~|((i_addr ^ i_match[g]) & i_mask[g]);
            wire ctrl_hit = ~|((i_ctrl ^ i_ctrl_val[g]) & i_ctrl_care[g]);
            wire space_hit = ~i_code_only[g] | i_code;
            assign o_sel[g] = addr_hit & ctrl_hit & space_hit;
        end
    endgenerate

endmodule
`default_nettype wire

// [sim/host_bus_model.sv]
/*
 * Behavioural host processor on the parallel address/data bus.
 * Assumes the bench calls its tasks and merges its port bytes with the
 * device's drive; pins change only at the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
    input wire logic i_clk,
    output logic o_ale,
    output logic [7:0] o_lo,
    output logic [7:0] o_hi,
    output logic [2:0] o_ctrl
);
    // ------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------
    initial begin
        o_ale = 1'b0;
        o_lo = 8'h00;
        o_hi = 8'h00;
        o_ctrl = 3'b111;
    end

    // address phase; released lines show the inverse, not stale data
    task automatic addr_phase(input logic [7:0] lo, input logic [7:0] hi,
                              input logic rel_lo, input logic rel_hi,
                              input int len);
        @(negedge i_clk);
        o_lo = lo;
        o_hi = hi;
        o_ale = 1'b1;
        repeat (len) @(negedge i_clk);
        o_ale = 1'b0;
        repeat (len) @(negedge i_clk);
        if (rel_lo) o_lo = ~lo;
        if (rel_hi) o_hi = ~hi;
    endtask

    // data phase of a write
    task automatic drive_data(input logic [7:0] lo, input logic [7:0] hi);
        @(negedge i_clk);
        o_lo = lo;
        o_hi = hi;
    endtask

    // control levels {third, second, first}
    task automatic set_ctrl(input logic [2:0] c);
        @(negedge i_clk);
        o_ctrl = c;
    endtask
endmodule

`default_nettype wire

// [sim/tb_mcu_bus_interface.sv]
/*
 * Self-checking bench for the parallel bus port: reads in every bus and
 * strobe mode, a decode miss, code fetch and writes.
 * Assumes the default select count of four.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_mcu_bus_interface;
    logic clk = 1'b0;
    logic rst_n;
    mcu_bus_pkg::cfg_t cfg, cas;
    mcu_bus_pkg::cycle_t cyc;
    logic ale;
    logic [2:0] ctrl;
    logic [7:0] host_lo, host_hi, lo_out, hi_out;
    wire logic [7:0] lo_pin, hi_pin;
    logic lo_oe_n, hi_oe_n;
    logic [3:0][19:0] match;
    logic [3:0] code_only, sel;
    logic [15:0] rd_data, wr_data;
    logic [2:0] ctrl_lv;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // clock, pins, instances
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    assign lo_pin = lo_oe_n ? host_lo : lo_out;
    assign hi_pin = hi_oe_n ? host_hi : hi_out;

    host_bus_model host_u (.i_clk(clk), .o_ale(ale), .o_lo(host_lo),
        .o_hi(host_hi), .o_ctrl(ctrl));

    mcu_bus_interface dut_u (.I_CLK(clk), .I_RESET_N(rst_n), .I_CFG(cfg),
        .I_LOW_ADDR_DATA_PORT(lo_pin), .O_LOW_ADDR_DATA_PORT(lo_out),
        .O_LOW_ADDR_DATA_PORT_OE_N(lo_oe_n),
        .I_HIGH_ADDR_DATA_PORT(hi_pin), .O_HIGH_ADDR_DATA_PORT(hi_out),
        .O_HIGH_ADDR_DATA_PORT_OE_N(hi_oe_n),
        .I_ADDRESS_STROBE_IN(ale ^ cfg.strobe_active_low),
        .I_WRITE_CTRL_INPUT(ctrl[0]), .I_READ_CTRL_INPUT(ctrl[1]),
        .I_PROGRAM_SELECT_INPUT(ctrl[2]), .I_SEL_MATCH(match),
        .I_SEL_MASK({4{20'hF_FFFF}}), .I_SEL_CODE_ONLY(code_only),
        .I_SEL_CTRL_CARE({3'h0, 3'h0, 3'h2, 3'h0}),
        .I_SEL_CTRL_VAL({4{3'h0}}),
        .I_RD_DATA(rd_data), .O_CYCLE(cyc), .O_SEL(sel),
        .O_CTRL_LEVELS(ctrl_lv), .O_WR_DATA(wr_data));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic mcu_bus_pkg::cfg_t mk(
        input mcu_bus_pkg::bus_mode_t b, input mcu_bus_pkg::ctrl0_mode_t c0,
        input mcu_bus_pkg::ctrl1_mode_t c1, input logic f2);
        mk = '{bus_mode: b, ctrl0_mode: c0, ctrl1_mode: c1,
               fetch_on_ctrl2: f2, strobe_active_low: 1'b0};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end

    // one read cycle; lo_on/hi_on say which port should drive
    task automatic run_read(input mcu_bus_pkg::cfg_t c, input logic [7:0] lo,
        input logic [7:0] hi, input logic rel_lo, input logic rel_hi,
        input logic [19:0] ea, input logic hit, input logic lo_on,
        input logic hi_on, input logic [2:0] on, input logic [2:0] idle);
        int n;
        @(negedge clk);
        cfg = c;
        match[0] = hit ? ea : ~ea;
        match[1] = match[0];
        code_only[0] = c.fetch_on_ctrl2;
        host_u.set_ctrl(idle);
        host_u.addr_phase(lo, hi, rel_lo, rel_hi, 6);
        host_u.set_ctrl(on);
        n = 0;
        while (lo_oe_n !== 1'b0 && hi_oe_n !== 1'b0 && n < 15) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        check(cyc.addr, ea);
        check(cyc.rd, 1'b1);
        check(cyc.code, c.fetch_on_ctrl2 & ~on[2]);
        check(ctrl_lv, on);
        check(sel[0], hit);
        check(sel[1], hit && !on[1]);
        check(lo_oe_n, !(hit && lo_on));
        check(hi_oe_n, !(hit && hi_on));
        if (hit && lo_on) check(lo_out, rd_data[7:0]);
        if (hit && hi_on) check(hi_out, c.bus_mode == mcu_bus_pkg::BUS_BURST ?
            rd_data[15:8] : rd_data[7:0]);
        host_u.set_ctrl(idle);
        repeat (8) @(negedge clk);
        check({lo_oe_n, hi_oe_n}, 2'b11);
        $display("read test done, mode %h", c);
    endtask

    // one write cycle in multiplexed mode
    task automatic run_write(input mcu_bus_pkg::cfg_t c, input logic [7:0] d,
        input logic [2:0] on, input logic [2:0] idle);
        int n;
        @(negedge clk);
        cfg = c;
        host_u.set_ctrl(idle);
        host_u.addr_phase(8'h56, 8'h0A, 1'b1, 1'b0, 6);
        host_u.drive_data(d, 8'h0A);
        host_u.set_ctrl(on);
        n = 0;
        while (cyc.wr !== 1'b1 && n < 15) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        check(cyc.wr, 1'b1);
        check(wr_data, {8'h0A, d});
        check({lo_oe_n, hi_oe_n}, 2'b11);
        host_u.set_ctrl(idle);
        repeat (8) @(negedge clk);
        $display("write test done, mode %h", c);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        cfg = mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_WRITE_STROBE,
                 mcu_bus_pkg::C1_READ_STROBE, 1'b0);
        match = '0;
        code_only = 4'h0;
        rd_data = 16'hA5C3;
        repeat (10) @(negedge clk);
        check({lo_oe_n, hi_oe_n, ctrl_lv}, 5'b11111);
        check(cyc, '0);
        check({sel, wr_data}, '0);
        check({lo_out, hi_out}, '0);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        check({lo_oe_n, hi_oe_n, cyc.rd, cyc.wr}, 4'b1100);
        $display("reset test done");
        run_read(mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_WRITE_STROBE,
            mcu_bus_pkg::C1_READ_STROBE, 1'b0), 8'h34, 8'h12, 1'b1, 1'b0,
            20'h0_1234, 1'b1, 1'b1, 1'b0, 3'b101, 3'b111);
        run_read(cfg, 8'h34, 8'h12, 1'b1, 1'b0, 20'h0_1234, 1'b0, 1'b1,
            1'b0, 3'b101, 3'b111);
        run_read(mk(mcu_bus_pkg::BUS_NONMUX, mcu_bus_pkg::C0_WRITE_STROBE,
            mcu_bus_pkg::C1_READ_STROBE, 1'b0), 8'hFF, 8'h80, 1'b0, 1'b0,
            20'h0_80FF, 1'b1, 1'b0, 1'b0, 3'b101, 3'b111);
        run_read(mk(mcu_bus_pkg::BUS_PAGE, mcu_bus_pkg::C0_WRITE_STROBE,
            mcu_bus_pkg::C1_READ_STROBE, 1'b0), 8'h01, 8'hFE, 1'b0, 1'b1,
            20'h0_FE01, 1'b1, 1'b0, 1'b1, 3'b101, 3'b111);
        run_read(mk(mcu_bus_pkg::BUS_BURST, mcu_bus_pkg::C0_WRITE_STROBE,
            mcu_bus_pkg::C1_READ_STROBE, 1'b0), 8'h34, 8'h12, 1'b1, 1'b1,
            20'h1_2340, 1'b1, 1'b1, 1'b1, 3'b101, 3'b111);
        run_read(mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_READ_NOT_WRITE,
            mcu_bus_pkg::C1_PHASE_CLOCK, 1'b0), 8'h9A, 8'h07, 1'b1, 1'b0,
            20'h0_079A, 1'b1, 1'b1, 1'b0, 3'b111, 3'b101);
        run_read(mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_READ_NOT_WRITE,
            mcu_bus_pkg::C1_DATA_STROBE, 1'b0), 8'h9B, 8'h07, 1'b1, 1'b0,
            20'h0_079B, 1'b1, 1'b1, 1'b0, 3'b101, 3'b111);
        run_read(mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_WRITE_STROBE,
            mcu_bus_pkg::C1_FETCH_READ, 1'b0), 8'h9C, 8'h07, 1'b1, 1'b0,
            20'h0_079C, 1'b1, 1'b1, 1'b0, 3'b101, 3'b111);
        run_read(mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_WRITE_STROBE,
            mcu_bus_pkg::C1_READ_STROBE, 1'b1), 8'h9D, 8'h07, 1'b1, 1'b0,
            20'h0_079D, 1'b1, 1'b1, 1'b0, 3'b011, 3'b111);
        // active-low address strobe: the pin is the model's strobe inverted
        cas = mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_WRITE_STROBE,
            mcu_bus_pkg::C1_READ_STROBE, 1'b0);
        cas.strobe_active_low = 1'b1;
        run_read(cas, 8'h9E, 8'h07, 1'b1, 1'b0, 20'h0_079E, 1'b1, 1'b1,
            1'b0, 3'b101, 3'b111);
        run_write(mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_WRITE_STROBE,
            mcu_bus_pkg::C1_READ_STROBE, 1'b0), 8'h5A, 3'b110, 3'b111);
        run_write(mk(mcu_bus_pkg::BUS_MUX, mcu_bus_pkg::C0_READ_NOT_WRITE,
            mcu_bus_pkg::C1_DATA_STROBE, 1'b0), 8'hA6, 3'b100, 3'b111);
        conclude();
    end
endmodule

`default_nettype wire
